// ==== shared/irq_nest_pkg.sv ====
// Constants, register map and carrier types of the interrupt nesting controller.
// Assumes a single 40 MHz clock shared with the instruction sequencer and an APB master.
`default_nettype none
package irq_nest_pkg;
	localparam int NUM_SRC = 8;
	localparam int NUM_VEC = 6;
	localparam int VEC_W = 3;
	localparam int VEC_ADDR_W = 12;
	localparam int APB_AW = 8;

	// APB register byte offsets
	localparam logic [7:0] OFS_PSW = 8'h00;
	localparam logic [7:0] OFS_STATUS_BIT = 8'h04;
	localparam logic [7:0] OFS_PRIO_SELECT = 8'h08;
	localparam logic [7:0] OFS_SRC_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_REQ_FLAGS = 8'h10;
	localparam logic [7:0] OFS_REQ_SET = 8'h14;
	localparam logic [7:0] OFS_EXT0_EDGE = 8'h18;
	localparam logic [7:0] OFS_EXT1_EDGE = 8'h1C;
	localparam logic [7:0] OFS_VEC_PRESET = 8'h20;
	localparam logic [7:0] OFS_ACK_INFO = 8'h24;

	// Field positions
	localparam int PSW_STATUS_LO = 2;
	localparam int PSW_STATUS_HI = 3;
	localparam int PRIO_GLOBAL_EN = 3;
	localparam int STBIT_VALUE = 4;

	// Reset values
	localparam logic [3:0] PSW_RESET = 4'h0;
	localparam logic [3:0] PRIO_RESET = 4'h0;
	localparam logic [NUM_SRC-1:0] ENABLE_RESET = 8'h00;
	localparam logic [3:0] EDGE_RESET = 4'h0;
	localparam logic [2*NUM_VEC-1:0] PRESET_RESET = 12'h000;

	// Processing status encodings
	localparam logic [1:0] ST_NORMAL = 2'b00;
	localparam logic [1:0] ST_LEVEL1 = 2'b01;
	localparam logic [1:0] ST_LEVEL2 = 2'b10;

	// Acknowledge processing length in machine cycles
	localparam logic [1:0] ACK_MCYCLES = 2'd3;

	// Source numbering; pairs 0/1 and 4/5 share a vector
	localparam int SRC_INTERVAL_TIMER = 0;
	localparam int SRC_EXT_FOUR = 1;
	localparam int SRC_EXT0 = 2;
	localparam int SRC_EXT1 = 3;
	localparam int SRC_SECOND_TIMER = 4;
	localparam int SRC_THIRD_TIMER = 5;

	localparam logic [VEC_ADDR_W-1:0] VEC_BASE = 12'h002;

	typedef struct packed {
		logic [VEC_ADDR_W-1:0] addr;
		logic memoryBankEnable;
		logic registerBankEnable;
	} vec_entry_t;

	typedef struct packed {
		logic machineTick;
		logic instrEnd;
		logic instrIsCtrl;
		logic eiExec;
		logic diExec;
		logic retiExec;
		logic [1:0] retiStatus;
	} seq_in_t;

	typedef enum logic [1:0] {
		SVC_IDLE = 2'b01,
		SVC_BUSY = 2'b10
	} svc_state_t;
endpackage
`default_nettype wire

// ==== hdl/irq_nest_ctrl.sv ====
// Interrupt nesting and acknowledge control with an APB register file.
// Assumes the instruction sequencer and all request sources run on clk; srcEvent pulses come from on-chip logic.
//
// Overview of operation
// R1: Edge select rewrite may raise its request flag.
// R2: Software waits 16 cycles before clearing flag.
// R3: Status bits are word bits 3,2; reset clears.
// R4: Status 0 accepts all; ack moves to 1.
// R5: High-priority acked in 0/1; ack 1 gives 2.
// R6: Status 2 acknowledges nothing; 3 unsupported.
// R7: Ack pushes status word, then advances status.
// R8: Return restores status bits from stack.
// R9: Status writable by nibble and bit, bank-independent.
// R10: Software disables interrupts around status changes.
// R11: Cleared status reopens acceptance for deep nesting.
// R12: Vector gives address and bank enable presets.
// R13: Shared-vector pairs OR their enabled flags.
// R14: Lone enabled source flag clears on ack.
// R15: Both enabled: ack clears neither flag.
// R16: Remaining flag keeps merged request active.
// R17: Control instruction touches interrupt hardware region.
// R18: Control instruction: one more instruction, then service.
// R19: Chained control instructions defer until after last.
// R20: Disable at/after flag set keeps it pending.
// R21: Flag in last cycle: one more instruction.
// R22: Flag earlier: service right after instruction.
// R23: Three service cycles perform the stack save.
// R24: Priority select: low three bits, bit3 enable.
// R25: Reset clears priority select, all disabled.
// R26: High priority first, others fixed order.
//
// The APB register port and the placing of the registers were left to the implementer.
`default_nettype none
module irq_nest_ctrl
	import irq_nest_pkg::*;
#(
	parameter int NUM_SOURCES = NUM_SRC
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [irq_nest_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_SOURCES-1:0] srcEvent,
	input wire irq_nest_pkg::seq_in_t seq,
	output logic ackStart,
	output logic ackBusy,
	output logic pushValid,
	output logic [3:0] pushWord,
	output irq_nest_pkg::vec_entry_t entry,
	output logic [1:0] statusOut
);
	import irq_nest_pkg::*;

	// Vector index of each source; sources 0/1 and 4/5 share
	function automatic logic [VEC_W-1:0] vecOf(input int src);
		case (src)
			0, 1: vecOf = 3'd0;
			2: vecOf = 3'd1;
			3: vecOf = 3'd2;
			4, 5: vecOf = 3'd3;
			6: vecOf = 3'd4;
			default: vecOf = 3'd5;
		endcase
	endfunction

	// Lowest set vector index, the fixed hardware order
	function automatic logic [VEC_W-1:0] firstVec(input logic [NUM_VEC-1:0] v);
		firstVec = 3'd0;
		for (int i = NUM_VEC - 1; i >= 0; i--)
		begin
			if (v[i])
				firstVec = i[VEC_W-1:0];
		end
	endfunction

	logic [3:0] program_status_word;
	logic [3:0] prioSelect;
	logic [NUM_SOURCES-1:0] srcEnable;
	logic [NUM_SOURCES-1:0] reqFlag;
	logic [3:0] ext0Edge;
	logic [3:0] ext1Edge;
	logic [2*NUM_VEC-1:0] vecPreset;
	logic early;
	logic ctrlSeen;
	logic [1:0] svcCount;
	svc_state_t svcState;

	// APB decode
	wire setupPhase = psel & ~penable;
	wire accessPhase = psel & penable;
	wire wrStrobe = accessPhase & pwrite;
	wire hitPsw = (paddr == OFS_PSW);
	wire hitStBit = (paddr == OFS_STATUS_BIT);
	wire hitPrio = (paddr == OFS_PRIO_SELECT);
	wire hitEnable = (paddr == OFS_SRC_ENABLE);
	wire hitFlags = (paddr == OFS_REQ_FLAGS);
	wire hitSet = (paddr == OFS_REQ_SET);
	wire hitEdge0 = (paddr == OFS_EXT0_EDGE);
	wire hitEdge1 = (paddr == OFS_EXT1_EDGE);
	wire hitPreset = (paddr == OFS_VEC_PRESET);
	wire hitInfo = (paddr == OFS_ACK_INFO);
	wire mapped = hitPsw | hitStBit | hitPrio | hitEnable | hitFlags | hitSet | hitEdge0 | hitEdge1 | hitPreset
		| hitInfo;

	wire [1:0] status = program_status_word[PSW_STATUS_HI:PSW_STATUS_LO]; // [R3]
	wire globalEnable = prioSelect[PRIO_GLOBAL_EN]; // [R24]
	wire [VEC_W-1:0] hiVec = prioSelect[VEC_W-1:0]; // [R24]

	// Merged per-vector requests
	wire [NUM_SOURCES-1:0] reqLive = reqFlag & srcEnable;
	logic [NUM_VEC-1:0] vecReq;
	logic [NUM_VEC-1:0] vecBothOn;
	genvar gv;
	generate
		for (gv = 0; gv < NUM_VEC; gv++)
		begin : g_vec
			logic [NUM_SOURCES-1:0] member;
			for (genvar gs = 0; gs < NUM_SOURCES; gs++)
			begin : g_member
				assign member[gs] = (vecOf(gs) == gv);
			end
			assign vecReq[gv] = |(reqLive & member); // [R13] [R16]
			assign vecBothOn[gv] = $countones(srcEnable & member) > 1;
		end
	endgenerate

	// Acceptance by status
	wire hiValid = (hiVec < NUM_VEC);
	wire hiPending = hiValid & vecReq[hiVec];
	wire lowAllowed = (status == ST_NORMAL); // [R4] [R11]
	wire hiAllowed = (status == ST_NORMAL) | (status == ST_LEVEL1); // [R5]
	wire eligible = globalEnable & ((hiPending & hiAllowed) | ((|vecReq) & lowAllowed)); // [R6] [R20]
	wire [VEC_W-1:0] selVec = (hiPending & hiAllowed) ? hiVec : firstVec(vecReq); // [R26]

	// Boundary decision
	wire ctrlInstr = seq.instrIsCtrl | ctrlSeen | seq.eiExec | seq.diExec | accessPhase; // [R17]
	wire boundary = seq.machineTick & seq.instrEnd;
	wire idle = (svcState == SVC_IDLE);
	assign ackStart = idle & boundary & ~ctrlInstr & early & eligible; // [R18] [R19] [R21] [R22]
	assign ackBusy = ~idle;
	assign pushValid = ackStart;
	assign pushWord = program_status_word; // [R7]
	assign statusOut = status;
	assign pready = 1'b1;

	// Status after acknowledge
	logic [1:0] advStatus;
	always_comb
	begin
		case (status)
			ST_NORMAL: advStatus = ST_LEVEL1; // [R4]
			ST_LEVEL1: advStatus = ST_LEVEL2; // [R5]
			default: advStatus = status;
		endcase
	end

	// Flag clears on acknowledge
	logic [NUM_SOURCES-1:0] ackClear;
	generate
		for (gv = 0; gv < NUM_SOURCES; gv++)
		begin : g_clr
			assign ackClear[gv] = ackStart & (selVec == vecOf(gv)) & srcEnable[gv] & ~vecBothOn[vecOf(gv)]; // [R14] [R15]
		end
	endgenerate

	// Edge select rewrites that raise a flag
	wire edge0Change = wrStrobe & hitEdge0 & (pwdata[3:0] != ext0Edge); // [R1]
	wire edge1Change = wrStrobe & hitEdge1 & (pwdata[3:0] != ext1Edge); // [R1]
	logic [NUM_SOURCES-1:0] edgeSet;
	always_comb
	begin
		edgeSet = '0;
		edgeSet[SRC_EXT0] = edge0Change;
		edgeSet[SRC_EXT1] = edge1Change;
	end

	wire [NUM_SOURCES-1:0] swSet = (wrStrobe & hitSet) ? pwdata[NUM_SOURCES-1:0] : '0;
	wire [NUM_SOURCES-1:0] swClear = (wrStrobe & hitFlags) ? pwdata[NUM_SOURCES-1:0] : '0;
	wire [NUM_SOURCES-1:0] flagSet = srcEvent | swSet | edgeSet;
	// Set wins over any clear arriving in the same cycle
	wire [NUM_SOURCES-1:0] next_reqFlag = flagSet | (reqFlag & ~swClear & ~ackClear);

	// Program status word next value: ack, then return, then software
	logic [3:0] stBitWord;
	always_comb
	begin
		stBitWord = program_status_word;
		if (pwdata[0])
			stBitWord[PSW_STATUS_LO] = pwdata[STBIT_VALUE];
		if (pwdata[1])
			stBitWord[PSW_STATUS_HI] = pwdata[STBIT_VALUE];
	end

	logic [3:0] next_psw;
	always_comb
	begin
		next_psw = program_status_word;
		if (ackStart)
			next_psw[PSW_STATUS_HI:PSW_STATUS_LO] = advStatus; // [R7]
		else if (seq.retiExec)
			next_psw[PSW_STATUS_HI:PSW_STATUS_LO] = seq.retiStatus; // [R8]
		else if (wrStrobe & hitPsw)
			next_psw = pwdata[3:0]; // [R9]
		else if (wrStrobe & hitStBit)
			next_psw = stBitWord; // [R9]
	end

	logic [3:0] next_prio;
	always_comb
	begin
		next_prio = prioSelect;
		if (wrStrobe & hitPrio)
			next_prio = pwdata[3:0];
		if (seq.eiExec)
			next_prio[PRIO_GLOBAL_EN] = 1'b1; // [R24]
		if (seq.diExec)
			next_prio[PRIO_GLOBAL_EN] = 1'b0; // [R20]
	end

	// Latency tracking: early means the request was seen before the final cycle
	logic next_early;
	always_comb
	begin
		next_early = early;
		if (ackStart | ~idle)
			next_early = 1'b0;
		else if (boundary)
			next_early = eligible; // [R19] [R21]
		else if (seq.machineTick)
			next_early = early | eligible; // [R22]
	end

	wire next_ctrlSeen = boundary ? 1'b0 : (ctrlSeen | ctrlInstr);

	// Service sequencer: three machine cycles of stack work
	svc_state_t next_svcState;
	logic [1:0] next_svcCount;
	always_comb
	begin
		next_svcState = svcState;
		next_svcCount = svcCount;
		case (svcState)
			SVC_IDLE:
			begin
				if (ackStart)
				begin
					next_svcState = SVC_BUSY;
					next_svcCount = ACK_MCYCLES; // [R23]
				end
			end
			SVC_BUSY:
			begin
				if (seq.machineTick)
				begin
					next_svcCount = svcCount - 2'd1;
					if (svcCount == 2'd1)
						next_svcState = SVC_IDLE; // [R18]
				end
			end
			default:
				next_svcState = SVC_IDLE;
		endcase
	end

	// Vector entry loaded at acknowledge
	vec_entry_t next_entry;
	always_comb
	begin
		next_entry = entry;
		if (ackStart)
		begin
			next_entry.addr = VEC_BASE + {{(VEC_ADDR_W-VEC_W-1){1'b0}}, selVec, 1'b0}; // [R12]
			next_entry.memoryBankEnable = vecPreset[2*selVec+1]; // [R12]
			next_entry.registerBankEnable = vecPreset[2*selVec]; // [R12]
		end
	end

	// Read data, captured in the setup phase so the zero-wait access sees it
	logic [31:0] next_rdata;
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (hitPsw)
			next_rdata[3:0] = program_status_word;
		else if (hitStBit)
			next_rdata[1:0] = status;
		else if (hitPrio)
			next_rdata[3:0] = prioSelect;
		else if (hitEnable)
			next_rdata[NUM_SOURCES-1:0] = srcEnable;
		else if (hitFlags)
			next_rdata[NUM_SOURCES-1:0] = reqFlag;
		else if (hitEdge0)
			next_rdata[3:0] = ext0Edge;
		else if (hitEdge1)
			next_rdata[3:0] = ext1Edge;
		else if (hitPreset)
			next_rdata[2*NUM_VEC-1:0] = vecPreset;
		else if (hitInfo)
			next_rdata[VEC_W+3:0] = {firstVec(vecReq), ackBusy, eligible, status};
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			program_status_word <= PSW_RESET; // [R3]
			prioSelect <= PRIO_RESET; // [R25]
			srcEnable <= ENABLE_RESET;
			reqFlag <= '0;
			ext0Edge <= EDGE_RESET;
			ext1Edge <= EDGE_RESET;
			vecPreset <= PRESET_RESET;
			early <= 1'b0;
			ctrlSeen <= 1'b0;
			svcState <= SVC_IDLE;
			svcCount <= 2'd0;
			entry <= '0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			program_status_word <= next_psw;
			prioSelect <= next_prio;
			reqFlag <= next_reqFlag;
			early <= next_early;
			ctrlSeen <= next_ctrlSeen;
			svcState <= next_svcState;
			svcCount <= next_svcCount;
			entry <= next_entry;
			if (wrStrobe & hitEnable)
				srcEnable <= pwdata[NUM_SOURCES-1:0];
			if (wrStrobe & hitEdge0)
				ext0Edge <= pwdata[3:0];
			if (wrStrobe & hitEdge1)
				ext1Edge <= pwdata[3:0];
			if (wrStrobe & hitPreset)
				vecPreset <= pwdata[2*NUM_VEC-1:0];
			if (setupPhase)
			begin
				prdata <= next_rdata;
				pslverr <= ~mapped;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/irq_nest_ctrl_asserts.sv ====
// Checker for the interrupt nesting controller, bound to its top module.
// Assumes the sequencer model ticks once per clock.
`default_nettype none
module irq_nest_ctrl_asserts
	import irq_nest_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire irq_nest_pkg::seq_in_t seq,
	input wire logic ackStart,
	input wire logic ackBusy,
	input wire logic pushValid,
	input wire logic [3:0] pushWord,
	input wire irq_nest_pkg::vec_entry_t entry,
	input wire logic [1:0] statusOut
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	chk_push_word: assert property (ackStart |-> pushValid ##1 (statusOut == $past(pushWord[3:2]) + 2'd1))
		else $error("push word wrong");
	chk_ack_boundary: assert property (ackStart |-> seq.instrEnd && !seq.instrIsCtrl && !ackBusy)
		else $error("ack off boundary");
	chk_status_zero: assert property (ackStart && statusOut == ST_NORMAL |=> statusOut == ST_LEVEL1)
		else $error("status 0 not advanced");
	chk_status_one: assert property (ackStart && statusOut == ST_LEVEL1 |=> statusOut == ST_LEVEL2)
		else $error("status 1 not advanced");
	chk_status_two: assert property (statusOut == ST_LEVEL2 |-> !ackStart)
		else $error("ack in status 2");
	chk_return_from_interrupt_restore: assert property (seq.retiExec && !ackStart |=> statusOut == $past(seq.retiStatus))
		else $error("return lost status");
	chk_busy_len: assert property (ackStart |=> ackBusy [*3] ##1 !ackBusy)
		else $error("service length wrong");
	chk_vector_addr: assert property (ackStart |=> !entry.addr[0] && entry.addr >= VEC_BASE && entry.addr <= 12'h00C)
		else $error("vector address wrong");
	cover property (ackStart && statusOut == ST_LEVEL1);
	cover property (seq.retiExec);
	cover property (statusOut == ST_LEVEL2);
	cover property (seq.diExec);
endmodule
bind irq_nest_ctrl irq_nest_ctrl_asserts u_chk (.clk, .rst_b, .seq, .ackStart, .ackBusy, .pushValid, .pushWord,
	.entry, .statusOut);
`default_nettype wire

// ==== verif/seq_model.sv ====
// Sequencer and stack model: two-cycle instructions, one machine tick per clock.
// Assumes the controller pushes on pushValid; a return pops at the next instruction end.
// opReq marks the next instruction as control (1), disable (2) or enable (3); it is held until it runs.
`default_nettype none
module seq_model
	import irq_nest_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic retiReq,
	input wire logic [1:0] opReq,
	input wire logic pushValid,
	input wire logic [3:0] pushWord,
	input wire logic ackBusy,
	output irq_nest_pkg::seq_in_t seq
);
	logic [1:0] stack [0:7];
	logic [2:0] sp;
	logic phase;
	logic retiPend;
	logic [1:0] opPend;
	always_ff @(posedge clk)
	begin
		phase <= rst_b && !ackBusy && !phase;
		opPend <= !rst_b ? 2'd0 : (opReq != 2'd0) ? opReq : seq.instrEnd ? 2'd0 : opPend;
		retiPend <= rst_b && (retiReq || (retiPend && !seq.retiExec));
		if (!rst_b)
			sp <= 3'h0;
		else if (pushValid)
			sp <= sp + 3'h1;
		else if (seq.retiExec)
			sp <= sp - 3'h1;
		if (pushValid)
			stack[sp] <= pushWord[3:2];
	end
	// Instruction flow pauses while the three service cycles run
	always_comb
	begin
		seq = '0;
		seq.machineTick = rst_b;
		seq.instrEnd = phase && !ackBusy;
		seq.retiExec = seq.instrEnd && retiPend;
		seq.instrIsCtrl = seq.instrEnd && opPend != 2'd0;
		seq.diExec = seq.instrEnd && opPend == 2'd2;
		seq.eiExec = seq.instrEnd && opPend == 2'd3;
		seq.retiStatus = stack[sp - 3'h1];
	end
endmodule
`default_nettype wire

// ==== verif/test_interrupt_nesting_and_ack_control.sv ====
// Self-checking bench of the interrupt nesting controller over APB.
// Assumes seq_model as sequencer and the bound checker.
`default_nettype none
module test_interrupt_nesting_and_ack_control;
	timeunit 1ns;
	timeprecision 100ps;
	import irq_nest_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, retiReq, ackStart, ackBusy, pushValid, pready, pslverr, seen, err;
	logic [7:0] paddr, srcEvent;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pushWord, pw;
	logic [1:0] statusOut, opReq;
	seq_in_t seq;
	vec_entry_t entry;
	int badCount, nChecks, cyc;
	irq_nest_ctrl DUT (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.srcEvent, .seq, .ackStart, .ackBusy, .pushValid, .pushWord, .entry, .statusOut);
	seq_model partner (.clk, .rst_b, .retiReq, .opReq, .pushValid, .pushWord, .ackBusy, .seq);
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			badCount++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp)
		begin
			badCount++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic pulse(input logic [7:0] m, input logic r);
		@(posedge clk);
		srcEvent <= m;
		retiReq <= r;
		@(posedge clk);
		srcEvent <= 8'h00;
		retiReq <= 0;
	endtask
	// Waits a bounded time for an acknowledge, then checks the loaded vector
	task automatic ack(input logic exp, input logic [11:0] addr);
		seen = 0;
		for (int i = 0; i < 20 && !seen; i++)
		begin
			@(negedge clk);
			seen = ackStart === 1'b1;
			pw = pushWord;
		end
		chk(seen, exp);
		if (seen)
		begin
			@(negedge clk);
			chk(entry.addr, addr);
		end
	endtask
	task automatic t_reset;
		apb(0, OFS_PSW, 0);
		chk(rd, PSW_RESET);
		apb(0, OFS_PRIO_SELECT, 0);
		chk(rd, PRIO_RESET);
		apb(1, OFS_EXT0_EDGE, 1);
		apb(0, OFS_REQ_FLAGS, 0);
		chk(rd, 8'h04);
		apb(1, OFS_SRC_ENABLE, 8'h04);
		ack(0, 0);
		repeat (16) @(posedge clk);
		apb(1, OFS_REQ_FLAGS, 8'h04);
		apb(0, 8'h40, 0);
		chk(err, 1);
	endtask
	task automatic t_basic;
		apb(1, OFS_PRIO_SELECT, 8'h08);
		pulse(8'h04, 0);
		ack(1, 12'h004);
		chk(pw, 0);
		chk(statusOut, ST_LEVEL1);
	endtask
	task automatic t_nest;
		apb(1, OFS_SRC_ENABLE, 8'h0D);
		pulse(8'h08, 0);
		ack(0, 0);
		pulse(8'h01, 0);
		ack(1, 12'h002);
		chk(statusOut, ST_LEVEL2);
		apb(0, OFS_REQ_FLAGS, 0);
		chk(rd, 8'h08);
		pulse(8'h01, 0);
		ack(0, 0);
		apb(1, OFS_REQ_FLAGS, 8'h01);
		pulse(0, 1);
		repeat (8) @(negedge clk);
		chk(statusOut, ST_LEVEL1);
	endtask
	task automatic t_clear;
		apb(1, OFS_PRIO_SELECT, 0);
		apb(1, OFS_STATUS_BIT, 8'h03);
		@(negedge clk);
		chk(statusOut, ST_NORMAL);
		apb(1, OFS_PRIO_SELECT, 8'h08);
		ack(1, 12'h006);
		chk(pw, 0);
	endtask
	task automatic t_shared;
		apb(1, OFS_PRIO_SELECT, 0);
		apb(1, OFS_PSW, 0);
		apb(1, OFS_SRC_ENABLE, 8'h03);
		pulse(8'h03, 0);
		apb(1, OFS_PRIO_SELECT, 8'h08);
		ack(1, 12'h002);
		chk(pw, 0);
		apb(0, OFS_REQ_FLAGS, 0);
		chk(rd, 8'h03);
		apb(1, OFS_REQ_FLAGS, 8'h01);
		ack(1, 12'h002);
		chk(statusOut, ST_LEVEL2);
		apb(0, OFS_REQ_FLAGS, 0);
		chk(rd, 8'h02);
	endtask
	// One instruction of kind o (1 control, 2 disable, 3 enable), with request pulses m beside it
	task automatic issue(input logic [1:0] o, input logic [7:0] m);
		@(posedge clk);
		opReq <= o;
		srcEvent <= m;
		@(posedge clk);
		opReq <= 2'd0;
		srcEvent <= 8'h00;
	endtask
	// Cycles from the end of the last control instruction to the acknowledge
	task automatic latency(input int exp);
		int n;
		n = 0;
		do @(negedge clk); while (!(seq.instrEnd && seq.instrIsCtrl));
		do
		begin
			@(negedge clk);
			n++;
		end
		while (ackStart !== 1'b1 && n < 20);
		chk(n, exp);
	endtask
	// Pulses source 2 in the cycle after one with instrEnd == fin; counts from the first cycle the flag reads set
	task automatic timed(input logic fin, input int exp);
		int n;
		n = 0;
		do @(negedge clk); while (seq.instrEnd !== fin);
		@(posedge clk);
		srcEvent <= 8'h04;
		@(posedge clk);
		srcEvent <= 8'h00;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (ackStart !== 1'b1 && n < 20);
		chk(n, exp);
	endtask
	task automatic reopen;
		apb(1, OFS_PRIO_SELECT, 0);
		apb(1, OFS_PSW, 0);
		apb(1, OFS_PRIO_SELECT, 8'h08);
	endtask
	// The model runs two-cycle instructions, so one further instruction is two cycles
	task automatic t_latency;
		apb(1, OFS_PRIO_SELECT, 0);
		apb(1, OFS_REQ_FLAGS, 8'hFF);
		apb(1, OFS_SRC_ENABLE, 8'h04);
		apb(1, OFS_PSW, 0);
		apb(1, OFS_PRIO_SELECT, 8'h08);
		issue(2'd2, 8'h04);
		ack(0, 0);
		apb(0, OFS_REQ_FLAGS, 0);
		chk(rd, 8'h04);
		issue(2'd3, 8'h00);
		latency(2);
		reopen();
		issue(2'd1, 8'h04);
		issue(2'd1, 8'h00);
		latency(2);
		reopen();
		timed(1'b0, 2);
		reopen();
		timed(1'b1, 3);
	endtask
	initial
	begin
		{rst_b, psel, penable, pwrite, retiReq} = '0;
		{paddr, pwdata, srcEvent, opReq} = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1;
		t_reset();
		t_basic();
		t_nest();
		t_clear();
		t_shared();
		t_latency();
		tally_and_finish();
	end
endmodule
`default_nettype wire
